// *** hw/spi_port_pkg.sv ***
// Constants for the byte-wide serial port block
package spi_port_pkg;
	// ****************************************
	// Register offsets and fields
	// ****************************************
	localparam logic [7:0] CTRL_OFFSET = 8'h2c;
	localparam logic [7:0] STAT_OFFSET = 8'h2d;
	localparam logic [7:0] DATA_OFFSET = 8'h2e;
	localparam int CTRL_IE_BIT = 7;
	localparam int CTRL_EN_BIT = 6;
	localparam int CTRL_ORD_BIT = 5;
	localparam int CTRL_MASTER_SELECT_BIT_BIT = 4;
	localparam int CTRL_CLOCK_POLARITY_BIT_BIT = 3;
	localparam int CTRL_CLOCK_PHASE_BIT_BIT = 2;
	localparam int STAT_DONE_BIT = 7;
	localparam int STAT_WRITE_COLLISION_FLAG_BIT = 6;
	localparam int STAT_2X_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// ****************************************
	// Timing
	// ****************************************
	localparam int BITS_PER_BYTE = 8;
	localparam logic [6:0] HALF_DIV_4 = 7'h01;
	localparam logic [6:0] HALF_DIV_16 = 7'h07;
	localparam logic [6:0] HALF_DIV_64 = 7'h1f;
	localparam logic [6:0] HALF_DIV_128 = 7'h3f;
	localparam logic [6:0] HALF_DIV_2 = 7'h00;
	localparam logic [6:0] HALF_DIV_8 = 7'h03;
	localparam logic [6:0] HALF_DIV_32 = 7'h0f;
	typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} xfer_state_t;
endpackage

// *** hw/sck_rate_gen.sv ***
// Master clock rate divider producing half-period enable pulses
`timescale 1ns/10ps
`default_nettype none
module sck_rate_gen
	import spi_port_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [1:0] rate_sel,
	input wire logic double_speed,
	output logic half_tick
);
	logic [6:0] cnt_q;
	logic [6:0] limit;

	// ****************************************
	// Divider select
	// ****************************************
	// normal and double speed rate dividers
	always_comb begin
		case ({double_speed, rate_sel})
			3'b000: limit = HALF_DIV_4;
			3'b001: limit = HALF_DIV_16;
			3'b010: limit = HALF_DIV_64;
			3'b011: limit = HALF_DIV_128;
			3'b100: limit = HALF_DIV_2;
			3'b101: limit = HALF_DIV_8;
			3'b110: limit = HALF_DIV_32;
			default: limit = HALF_DIV_64;
		endcase
	end

	// Counter restarts whenever the generator is stopped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 7'h00;
		end else if (!run || cnt_q >= limit) begin
			cnt_q <= 7'h00;
		end else begin
			cnt_q <= cnt_q + 7'h01;
		end
	end

	assign half_tick = run && (cnt_q >= limit);
endmodule // sck_rate_gen
`default_nettype wire

// *** hw/pin_sync.sv ***
// Two-flop synchroniser for the slave clock and select pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '1;
			sync_out <= '1;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // pin_sync
`default_nettype wire

// *** hw/spi_master_slave_port.sv ***
// Byte-wide serial port, master or slave, with CPU registers
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_port
	import spi_port_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic global_int_enable,
	input wire logic vector_taken,
	output logic irq,
	input wire logic ss_is_output,
	input wire logic miso_user_output,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic ss_n_in
);
	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] ctrl_q;
	logic done_q;
	logic write_collision_flag_q;
	logic dbl_q;
	logic [7:0] shift_q;
	logic [7:0] rxbuf_q;
	logic armed_q;
	logic [3:0] bits_q;
	xfer_state_t state_q;
	logic sck_lvl_q;
	logic out_bit_q;
	logic in_bit_q;
	logic [1:0] pins_s;
	logic sck_s_q;
	logic ss_s_q;
	logic half_tick;

	wire logic en = ctrl_q[CTRL_EN_BIT];
	wire logic master_select_bit = ctrl_q[CTRL_MASTER_SELECT_BIT_BIT];
	wire logic clock_polarity_bit = ctrl_q[CTRL_CLOCK_POLARITY_BIT_BIT];
	wire logic clock_phase_bit = ctrl_q[CTRL_CLOCK_PHASE_BIT_BIT];
	wire logic lsb_first = ctrl_q[CTRL_ORD_BIT];
	wire logic data_wr = wr_en && addr == DATA_OFFSET;
	wire logic data_acc = (wr_en || rd_en) && addr == DATA_OFFSET;
	wire logic stat_rd = rd_en && addr == STAT_OFFSET;
	wire logic busy = state_q != ST_IDLE;
	wire logic sck_s = pins_s[1];
	wire logic ss_s = pins_s[0];

	// select low in master with input select
	wire logic mode_fault = en && master_select_bit && !ss_is_output && !ss_s;
	wire logic slave_act = en && !master_select_bit && !ss_s;
	wire logic slave_drop = en && !master_select_bit && ss_s;

	// Slave clock edges, after synchronisation
	wire logic sck_rise = sck_s && !sck_s_q;
	wire logic sck_fall = !sck_s && sck_s_q;
	wire logic lead_edge = clock_polarity_bit ? sck_fall : sck_rise;
	wire logic trail_edge = clock_polarity_bit ? sck_rise : sck_fall;
	wire logic sel_edge = !ss_s && ss_s_q;

	// Outgoing bit and received byte in bit order
	// order chosen by bit order select
	wire logic next_out = lsb_first ? shift_q[0] : shift_q[7];
	wire logic [7:0] shifted = lsb_first ? {in_bit_q, shift_q[7:1]}
		: {shift_q[6:0], in_bit_q};
	wire logic in_now = master_select_bit ? miso_in : mosi_in; // Data input of this role
	wire logic [7:0] captured = lsb_first ? {in_now, shift_q[7:1]}
		: {shift_q[6:0], in_now};

	// ****************************************
	// Helpers
	// ****************************************
	sck_rate_gen u_rate (
		.clk(clk),
		.rst_n(rst_n),
		.run(en && master_select_bit && busy),
		.rate_sel(ctrl_q[1:0]),
		.double_speed(dbl_q),
		.half_tick(half_tick)
	);

	pin_sync #(.WIDTH(2)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in({sck_in, ss_n_in}),
		.sync_out(pins_s)
	);

	// Previous synchronised levels for edge detect
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_s_q <= 1'b1;
			ss_s_q <= 1'b1;
		end else begin
			sck_s_q <= sck_s;
			ss_s_q <= ss_s;
		end
	end

	// ****************************************
	// Edge events for the shifter
	// ****************************************
	// Master: half ticks alternate lead/trail
	// phase picks sample edge
	// sample and setup on opposite edges
	logic do_lead;
	logic do_trail;
	always_comb begin
		do_lead = 1'b0;
		do_trail = 1'b0;
		if (en && master_select_bit && !mode_fault) begin
			do_lead = half_tick && state_q == ST_LEAD;
			do_trail = half_tick && state_q == ST_TRAIL;
		end else if (slave_act) begin
			do_lead = lead_edge;
			do_trail = trail_edge;
		end
	end
	// mode number is polarity and phase
	wire logic sample_ev = clock_phase_bit ? do_trail : do_lead;
	wire logic setup_ev = clock_phase_bit ? do_lead : do_trail;
	wire logic last_edge = do_trail && bits_q == 4'(BITS_PER_BYTE - 1);
	wire logic byte_done = last_edge;

	// ****************************************
	// Control register
	// ****************************************
	// master bit written by software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RESET;
		end else if (mode_fault) begin
			ctrl_q[CTRL_MASTER_SELECT_BIT_BIT] <= 1'b0;
		end else if (wr_en && addr == CTRL_OFFSET) begin
			ctrl_q <= wdata;
		end
	end

	// Double speed bit in status register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dbl_q <= STAT_RESET[STAT_2X_BIT];
		end else if (wr_en && addr == STAT_OFFSET) begin
			dbl_q <= wdata[STAT_2X_BIT];
		end
	end

	// Armed after a status read that saw a flag set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_q <= 1'b0;
		end else if (stat_rd) begin
			armed_q <= done_q || write_collision_flag_q;
		end else if (data_acc) begin
			armed_q <= 1'b0;
		end
	end

	// ****************************************
	// Flags, set wins over clear
	// ****************************************
	// set on byte done or mode fault
	// clear by vector or status-data pair
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else if (byte_done || mode_fault) begin
			done_q <= 1'b1;
		end else if (vector_taken || (armed_q && data_acc)) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_collision_flag_q <= 1'b0;
		end else if (data_wr && busy) begin
			write_collision_flag_q <= 1'b1;
		end else if (armed_q && data_acc) begin
			write_collision_flag_q <= 1'b0;
		end
	end

	// ****************************************
	// Transfer sequencer and shifter
	// ****************************************
	// master write starts, eight bits, stop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			bits_q <= 4'h0;
		end else if (!en || mode_fault || slave_drop) begin
			state_q <= ST_IDLE;
			bits_q <= 4'h0;
		end else if (state_q == ST_IDLE) begin
			if ((data_wr && master_select_bit) || (slave_act && sel_edge)) begin
				state_q <= ST_LEAD;
			end
			bits_q <= 4'h0;
		end else if (do_lead) begin
			state_q <= ST_TRAIL;
		end else if (do_trail) begin
			bits_q <= bits_q + 4'h1;
			state_q <= last_edge && master_select_bit ? ST_IDLE : ST_LEAD;
			if (last_edge) begin
				bits_q <= 4'h0;
			end
		end
	end

	// Slave starts only on a falling select edge; with select already low it stays idle
	// data write loads shifter when idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= DATA_RESET;
			in_bit_q <= 1'b0;
			out_bit_q <= 1'b0;
		end else if (data_wr && !busy) begin
			shift_q <= wdata;
			out_bit_q <= lsb_first ? wdata[0] : wdata[7];
		end else if (sample_ev) begin
			in_bit_q <= in_now;
			if (clock_phase_bit) begin
				shift_q <= captured;
			end
		end else if (setup_ev) begin
			if (!clock_phase_bit) begin
				shift_q <= shifted;
			end
			out_bit_q <= clock_phase_bit ? next_out
				: (lsb_first ? shifted[0] : shifted[7]);
		end
	end

	// completed byte kept in receive buffer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxbuf_q <= DATA_RESET;
		end else if (byte_done) begin
			rxbuf_q <= clock_phase_bit ? captured : shifted; // Phase 1: last bit still on the pin; phase 0: already in in_bit_q
		end
	end

	// Master clock level: toggles on each half tick
	// idle level equals polarity
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_lvl_q <= 1'b0;
		end else if (!busy || !master_select_bit) begin
			sck_lvl_q <= clock_polarity_bit;
		end else if (half_tick) begin
			sck_lvl_q <= !sck_lvl_q;
		end
	end

	// ****************************************
	// Pins and interrupt
	// ****************************************
	// MISO drives only when selected and user output
	// select pin untouched by master logic
	always_comb begin
		sck_out = sck_lvl_q;
		sck_oe = en && master_select_bit;
		mosi_out = out_bit_q;
		mosi_oe = en && master_select_bit;
		miso_out = out_bit_q;
		miso_oe = slave_act && miso_user_output;
	end

	// request while flag and enables set
	assign irq = done_q && ctrl_q[CTRL_IE_BIT] && global_int_enable;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (rd_en) begin
			case (addr)
				CTRL_OFFSET: rdata <= ctrl_q;
				STAT_OFFSET: rdata <= {done_q, write_collision_flag_q, 5'h00, dbl_q};
				DATA_OFFSET: rdata <= rxbuf_q;
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_irq_gating: assert property (
		irq |-> done_q && ctrl_q[CTRL_IE_BIT]) else $error("irq ungated");
	a_fault_fallback: assert property (
		mode_fault |=> !master_select_bit && done_q) else $error("no fall-back");
	a_write_collision_flag_set: assert property (
		data_wr && busy |=> write_collision_flag_q) else $error("collision missed");
	a_reserved_zero: assert property (
		$past(stat_rd) |-> rdata[5:1] == 5'h00) else $error("reserved set");
	a_disabled_idle: assert property (
		!en |=> !busy) else $error("active while disabled");
	a_slave_drop: assert property (
		slave_drop |=> bits_q == 4'h0 && !busy) else $error("no reset");
	a_miso_drive: assert property (
		miso_oe |-> !ss_s && !master_select_bit) else $error("miso driven");
	a_idle_level: assert property (
		!busy && master_select_bit && en |=> sck_out == $past(clock_polarity_bit)) else $error("idle level");
	a_done_sets: assert property (
		byte_done |=> done_q) else $error("done not set");
endmodule // spi_master_slave_port
`default_nettype wire

// *** tb/spi_slave_model.sv ***
// Far-side serial slave that shifts one byte in any mode
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel_n,
	input wire logic clock_polarity_bit,
	input wire logic clock_phase_bit,
	input wire logic lsb,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_byte
);
	int rx_n;
	int tx_n;
	logic skip;
	// Frame start puts both bit counters on the first bit
	always @(negedge sel_n) begin
		rx_n = 0;
		tx_n = 0;
		skip = clock_phase_bit;
	end
	// capture on the sample edge, launch on the other
	always @(sck) begin
		if (!sel_n && sck == (clock_polarity_bit == clock_phase_bit)) begin
			rx_byte[lsb ? (rx_n & 7) : 7 - (rx_n & 7)] = mosi;
			rx_n++;
		end else if (!sel_n) begin
			if (skip)
				skip = 1'b0;
			else
				tx_n++;
		end
	end
	// bit order; a released line shows no stale value
	assign miso = sel_n ? ~miso_last() : tx_byte[lsb ? (tx_n & 7) : 7 - (tx_n & 7)];
	function automatic logic miso_last();
		return tx_byte[lsb ? 7 : 0];
	endfunction
endmodule // spi_slave_model
`default_nettype wire

// *** tb/tb_spi_master_slave_port.sv ***
// Self-checking bench for the serial port block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; \
	if ((s) !== (e)) begin mismatches++; \
	$display("ERROR %s exp %h got %h", n, e, s); end end
module tb_spi_master_slave_port
	import spi_port_pkg::*;
;
	logic clk, rst_n, wr_en, rd_en, gie, vec, ss_cfg, miso_en, irq;
	logic ext_sck, ext_mosi, ss_n, sel_n, sck_out, sck_oe, sck_prev;
	logic mosi_out, mosi_oe, miso_out, miso_oe, m_miso;
	logic [7:0] addr, wdata, rdata, m_tx, m_rx, ctrl_v, d, got;
	int mismatches, checks_done, edges, first_c, last_c, cyc;
	int seed = 32'hff1ab4d4;
	int div_t[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
	// ****************************************
	// Design, far side and clock
	// ****************************************
	spi_master_slave_port dut_u (.clk(clk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.global_int_enable(gie), .vector_taken(vec), .irq(irq),
		.ss_is_output(ss_cfg), .miso_user_output(miso_en),
		.sck_in(ext_sck), .sck_out(sck_out), .sck_oe(sck_oe),
		.mosi_in(ext_mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
		.miso_in(m_miso), .miso_out(miso_out), .miso_oe(miso_oe),
		.ss_n_in(ss_n));
	spi_slave_model slave_u (.sck(sck_out), .mosi(mosi_out), .sel_n(sel_n),
		.clock_polarity_bit(ctrl_v[3]), .clock_phase_bit(ctrl_v[2]), .lsb(ctrl_v[5]), .tx_byte(m_tx),
		.miso(m_miso), .rx_byte(m_rx));
	always #25 clk = ~clk;
	// Counts serial clock toggles and when the first and last came
	always @(posedge clk) begin
		cyc++;
		if (sck_out !== sck_prev) begin
			edges++;
			if (edges == 1)
				first_c = cyc;
			last_c = cyc;
		end
		sck_prev = sck_out;
	end
	// ****************************************
	// Bus tasks
	// ****************************************
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask
	task wait_done(output logic [7:0] s);
		s = 8'h00;
		for (int i = 0; i < 1200 && !s[7]; i++)
			rd(STAT_OFFSET, s);
	endtask
	// A new polarity reaches the pin two edges after the control write
	task clear_edges();
		repeat (2) @(posedge clk);
		#1 edges = 0;
	endtask
	// One master byte against the far-side model
	task xfer(input logic [1:0] mode, input logic lsb, input logic [2:0] r);
		ctrl_v = {2'b01, lsb, 1'b1, mode, r[1:0]};
		m_tx = $random(seed);
		d = $random(seed);
		wr(STAT_OFFSET, {7'h00, r[2]});
		wr(CTRL_OFFSET, ctrl_v);
		clear_edges();
		sel_n <= 1'b0;
		wr(DATA_OFFSET, d);
		wait_done(got);
		`CHK("status", {7'h40, r[2]}, got)
		rd(DATA_OFFSET, got);
		`CHK("rx data", m_tx, got)
		`CHK("tx data", d, m_rx)
		`CHK("edges", 16, edges)
		`CHK("span", 15 * div_t[r] / 2, last_c - first_c)
		`CHK("idle", ctrl_v[3], sck_out)
		`CHK("sck oe", 1'b1, sck_oe)
		`CHK("mosi oe", 1'b1, mosi_oe)
		rd(STAT_OFFSET, got);
		`CHK("cleared", {7'h00, r[2]}, got)
		sel_n <= 1'b1;
	endtask
	// Far master in mode 0, six cycles a phase
	task sbyte(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			ext_mosi <= b[7 - i];
			repeat (6) @(posedge clk);
			got[7 - i] = miso_out;
			ext_sck <= 1'b1;
			repeat (6) @(posedge clk);
			ext_sck <= 1'b0;
		end
	endtask
	task results();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog cuts a hang short
	initial begin
		#3000000;
		mismatches++;
		results();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{clk, rst_n, wr_en, rd_en, gie, vec, ss_cfg, miso_en} = 8'h00;
		{ext_sck, ext_mosi, ss_n, sel_n, sck_prev} = 5'b00110;
		{addr, wdata, ctrl_v, m_tx} = 32'h0;
		{mismatches, checks_done, edges, cyc} = 4'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(CTRL_OFFSET, got);
		`CHK("ctrl reset", CTRL_RESET, got)
		rd(8'h00, got);
		`CHK("unmapped", 8'h00, got)
		wr(STAT_OFFSET, 8'hff);
		rd(STAT_OFFSET, got);
		`CHK("reserved", 8'h01, got)
		wr(STAT_OFFSET, 8'h00);
		wr(CTRL_OFFSET, 8'h10);
		clear_edges();
		wr(DATA_OFFSET, 8'h96);
		repeat (40) @(posedge clk);
		`CHK("disabled", 0, edges)
		// Every mode, both orders and all eight rates; select held high
		for (int m = 0; m < 8; m++)
			xfer(m[2:1], m[0], m[2:0]);
		gie <= 1'b1;
		ctrl_v = 8'hd3;
		wr(STAT_OFFSET, 8'h00);
		wr(CTRL_OFFSET, ctrl_v);
		clear_edges();
		sel_n <= 1'b0;
		wr(DATA_OFFSET, 8'h11);
		wr(DATA_OFFSET, 8'h22);
		rd(STAT_OFFSET, got);
		`CHK("collision", 8'h40, got)
		wait_done(got);
		`CHK("both flags", 8'hc0, got)
		`CHK("sent once", 8'h11, m_rx)
		`CHK("irq", 1'b1, irq)
		gie <= 1'b0;
		@(posedge clk);
		#1 `CHK("irq gated", 1'b0, irq)
		gie <= 1'b1;
		vec <= 1'b1;
		@(posedge clk);
		vec <= 1'b0;
		rd(STAT_OFFSET, got);
		`CHK("vector", 8'h40, got)
		rd(DATA_OFFSET, got);
		rd(STAT_OFFSET, got);
		`CHK("write_collision_flag clear", 8'h00, got)
		sel_n <= 1'b1;
		wr(CTRL_OFFSET, 8'h50);
		ss_n <= 1'b0;
		repeat (4) @(posedge clk);
		rd(CTRL_OFFSET, got);
		`CHK("fall back", 8'h40, got)
		`CHK("sck released", 1'b0, sck_oe)
		`CHK("mosi released", 1'b0, mosi_oe)
		rd(STAT_OFFSET, got);
		`CHK("fall flag", 8'h80, got)
		rd(DATA_OFFSET, got);
		ss_n <= 1'b1;
		ss_cfg <= 1'b1;
		// Software sets master again after the fall-back
		wr(CTRL_OFFSET, 8'h50);
		ss_n <= 1'b0;
		repeat (4) @(posedge clk);
		rd(CTRL_OFFSET, got);
		`CHK("plain output", 8'h50, got)
		ss_n <= 1'b1;
		// Slave role: aborted partial byte, then a whole one
		wr(CTRL_OFFSET, 8'h40);
		ss_cfg <= 1'b0;
		miso_en <= 1'b1;
		wr(DATA_OFFSET, 8'ha5);
		ss_n <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK("miso drive", 1'b1, miso_oe)
		sbyte(8'hff, 3);
		ss_n <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK("miso off", 1'b0, miso_oe)
		rd(STAT_OFFSET, got);
		`CHK("abort", 8'h00, got)
		wr(DATA_OFFSET, 8'h5a);
		ss_n <= 1'b0;
		d = $random(seed);
		repeat (6) @(posedge clk);
		sbyte(d, 8);
		repeat (6) @(posedge clk);
		ss_n <= 1'b1;
		`CHK("miso bits", 8'h5a, got)
		repeat (6) @(posedge clk);
		rd(STAT_OFFSET, got);
		`CHK("slave done", 8'h80, got)
		rd(DATA_OFFSET, got);
		`CHK("slave rx", d, got)
		results();
	end
endmodule // tb_spi_master_slave_port
`default_nettype wire
